/* File: rtl/upc_defs.vh */
// Constants for the universal pulse counter: register map, field layout, timing.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef UPC_DEFS_VH
`define UPC_DEFS_VH

// Clock rate
`define UPC_CLK_HZ 20000000

// Channel count and count width
`define UPC_NCH 4
`define UPC_CW 32

// Register byte offsets; per-channel block of 0x20 bytes from 0x20
`define UPC_OFS_IRQ_STAT 8'h00
`define UPC_OFS_IRQ_MASK 8'h04
`define UPC_OFS_LOGCH 8'h08
`define UPC_OFS_CH_BASE 8'h20
`define UPC_CH_STRIDE 8'h20
`define UPC_SUB_CFG 3'h0
`define UPC_SUB_LOLIM 3'h1
`define UPC_SUB_HILIM 3'h2
`define UPC_SUB_COUNT 3'h3
`define UPC_SUB_FLAGS 3'h4

// Channel config fields
`define UPC_CFG_MODE_LSB 0
`define UPC_CFG_RSTSEL_LSB 2
`define UPC_CFG_PRG_LSB 4
`define UPC_CFG_FILT_LSB 8
`define UPC_CFG_LOGSEL_LSB 12
`define UPC_CFG_CLEARNOW_BIT 31

// Function modes
`define UPC_MODE_ADD 2'h0
`define UPC_MODE_SUB 2'h1
`define UPC_MODE_QUAD1 2'h2
`define UPC_MODE_QUAD4 2'h3

// Extra reset selection
`define UPC_RST_NONE 2'h0
`define UPC_RST_LOG 2'h1
`define UPC_RST_EXT 2'h2
`define UPC_RST_BOTH 2'h3

// Programming input function
`define UPC_PRG_OFF 2'h0
`define UPC_PRG_DIR 2'h1
`define UPC_PRG_INH 2'h2

// Filter settings: 0 off, 1..9 select 10..90 Hz
`define UPC_FILT_OFF 4'h0
`define UPC_FILT_STEP_HZ 10
`define UPC_FILT_MAX 4'h9

// Reset values
`define UPC_CFG_RST 32'h00000000
`define UPC_LOLIM_RST 32'h00000000
`define UPC_HILIM_RST 32'hffffffff

// Interrupt status bit layout per channel: low flag at 2n, high flag at 2n+1
`define UPC_IRQ_W 8

`endif

/* File: rtl/upc_chan.v */
// One counter channel: synchronisers, bounce filter, edge decode, counter.
// Assumes field inputs are asynchronous and config comes from ref_clk logic.
`timescale 1ns/1ps
`include "upc_defs.vh"

module upc_chan (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Field inputs
	input wire cntA,
	input wire cntB,
	input wire prgIn,
	input wire rstIn,
	// Configuration
	input wire [1:0] mode,
	input wire [1:0] rstSel,
	input wire [1:0] prgFunc,
	input wire [3:0] filtSel,
	input wire logReset,
	input wire clearNow,
	// Result
	output reg [`UPC_CW-1:0] count_ff
);
	// Half period of 10 Hz step in cycles; setting k gives half period / k
	localparam [31:0] HALF10 = `UPC_CLK_HZ / (2 * `UPC_FILT_STEP_HZ);

	reg [3:0] s1_ff; // First synchroniser stage, read only by s2_ff
	reg [3:0] s2_ff; // Second stage
	reg [3:0] flt_ff; // Filtered levels
	reg [3:0] prev_ff; // Filtered levels one cycle earlier
	reg [20:0] cnt_ff [0:3]; // Stability counters per input
	reg [20:0] limit; // Stability length for the current filter
	reg up;
	reg dn;
	reg pa;
	reg pb;
	reg prgAct;
	reg swap;
	integer i;

	// Two-flop synchronisers ahead of any logic
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s1_ff <= 4'h0;
			s2_ff <= 4'h0;
		end else begin
			s1_ff <= {rstIn, prgIn, cntB, cntA};
			s2_ff <= s1_ff;
		end
	end

	// Filter length; division done once per setting, cheap at this size
	always @* begin
		if (filtSel == `UPC_FILT_OFF || filtSel > `UPC_FILT_MAX)
			limit = 21'h0;
		else
			limit = HALF10[20:0] / {17'h0, filtSel};
	end

	// Bounce filter: a level must stand for limit+1 cycles before it is taken
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flt_ff <= 4'h0;
			prev_ff <= 4'h0;
			for (i = 0; i < 4; i = i + 1)
				cnt_ff[i] <= 21'h0;
		end else begin
			prev_ff <= flt_ff;
			for (i = 0; i < 4; i = i + 1) begin
				if (s2_ff[i] == flt_ff[i]) begin
					cnt_ff[i] <= 21'h0;
				end else if (cnt_ff[i] >= limit) begin
					// Short pulses never reach the limit and are dropped
					flt_ff[i] <= s2_ff[i];
					cnt_ff[i] <= 21'h0;
				end else begin
					cnt_ff[i] <= cnt_ff[i] + 21'h1;
				end
			end
		end
	end

	// Edge decode into one up or down step per cycle
	always @* begin
		pa = flt_ff[0] & ~prev_ff[0];
		pb = flt_ff[1] & ~prev_ff[1];
		prgAct = flt_ff[2] & (prgFunc != `UPC_PRG_OFF);
		swap = prgAct & (prgFunc == `UPC_PRG_DIR);
		up = 1'b0;
		dn = 1'b0;
		case (mode)
			`UPC_MODE_ADD: begin
				// Both edges together add only one in total; the second edge is
				// not counted in a later cycle, so the two are taken as one step
				up = pa | pb;
			end
			`UPC_MODE_SUB: begin
				up = swap ? (pb & ~pa) : (pa & ~pb);
				dn = swap ? (pa & ~pb) : (pb & ~pa);
			end
			`UPC_MODE_QUAD1: begin
				up = pa & (flt_ff[1] ^ swap);
				dn = pa & ~(flt_ff[1] ^ swap);
			end
			`UPC_MODE_QUAD4: begin
				// Simultaneous edges cancel as direction is ambiguous
				up = (pa & ~pb & (flt_ff[1] ^ swap)) | (pb & ~pa & (flt_ff[0] ^ swap));
				dn = (pa & ~pb & ~(flt_ff[1] ^ swap)) | (pb & ~pa & ~(flt_ff[0] ^ swap));
			end
			default: begin
				up = 1'b0;
			end
		endcase
		if (prgAct && prgFunc == `UPC_PRG_INH) begin
			up = 1'b0;
			dn = 1'b0;
		end
	end

	// Counter with its clears; clears win over counting
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			count_ff <= {`UPC_CW{1'b0}};
		end else if (clearNow) begin
			count_ff <= {`UPC_CW{1'b0}};
		end else if (((rstSel == `UPC_RST_LOG || rstSel == `UPC_RST_BOTH) && logReset) ||
			((rstSel == `UPC_RST_EXT || rstSel == `UPC_RST_BOTH) && flt_ff[3])) begin
			count_ff <= {`UPC_CW{1'b0}};
		end else if (up) begin
			count_ff <= count_ff + 32'h1;
		end else if (dn) begin
			count_ff <= count_ff - 32'h1;
		end
	end
endmodule // upc_chan

/* File: rtl/upc_top.v */
// Four-channel universal pulse counter with AXI4-Lite registers and interrupt.
// Assumes field pins are asynchronous; logical-channel values arrive on ref_clk.
//
// How it works
// - Four independent channels, each configured separately
// - Additive: either input rising adds one
// - Subtractive: input one adds, two subtracts
// - Quad single: input one edge, two sets direction
// - Quad four: either edge, other sets direction
// - Manual clear command zeroes the count
// - Extra reset: none, logical, external, both
// - Logical reset when chosen channel above zero
// - Programming input off means it is ignored
// - Direction function swaps or reverses counting in subtractive and quad modes
// - Inhibit function holds count while active
// - Filter off or 10..90 Hz, rejects bounces
// - Below-low and above-high flags reported
`timescale 1ns/1ps
`include "upc_defs.vh"

module upc_top (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Field pins, one bit per channel
	input wire [3:0] cntA,
	input wire [3:0] cntB,
	input wire [3:0] prgIn,
	input wire [3:0] rstIn,
	// Logical channel values from the recorder, signed, one per channel slot
	input wire [127:0] logChanVal,
	// Limit flags per channel
	output reg [3:0] below_low_flag_ff,
	output reg [3:0] above_high_flag_ff,
	// Interrupt
	output reg irq_ff,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	localparam [1:0] OKAY = 2'h0;
	localparam [1:0] SLVERR = 2'h2;

	reg [31:0] cfg_ff [0:3]; // Channel configuration
	reg [31:0] loLim_ff [0:3]; // Low limits, signed
	reg [31:0] hiLim_ff [0:3]; // High limits, signed
	reg [`UPC_IRQ_W-1:0] irqStat_ff; // Sticky flag-rise events
	reg [`UPC_IRQ_W-1:0] irqMask_ff; // Enable per event
	reg [3:0] clearNow_ff; // One-cycle manual clear pulses
	reg [3:0] logRst_ff; // Registered logical reset requests
	reg [7:0] awAddr_ff; // Latched write address
	reg awHave_ff;
	reg [31:0] wData_ff; // Latched write data
	reg [3:0] wStrb_ff;
	reg wHave_ff;
	wire [31:0] count [0:3];
	wire doWrite;
	reg [2:0] wSub;
	reg [1:0] wCh;
	reg wOk;
	reg [31:0] rdVal;
	reg rdOk;
	reg [2:0] rSub;
	reg [1:0] rCh;
	reg [7:0] rOff;
	reg [7:0] wOff;
	reg [`UPC_IRQ_W-1:0] flagRise;
	reg [31:0] merged;
	integer k; // Own index per process, so no variable has two drivers
	integer kLr; // Index of the logical reset process
	integer kFl; // Index of the flag process
	integer kFr; // Index of the flag-rise decode
	integer kMg; // Index of the byte-lane merge
	genvar g;

	// Instantiate the four channels
	generate
		for (g = 0; g < `UPC_NCH; g = g + 1) begin : gCh
			upc_chan uChan (
				.ref_clk(ref_clk),
				.reset(reset),
				.cntA(cntA[g]),
				.cntB(cntB[g]),
				.prgIn(prgIn[g]),
				.rstIn(rstIn[g]),
				.mode(cfg_ff[g][`UPC_CFG_MODE_LSB+1:`UPC_CFG_MODE_LSB]),
				.rstSel(cfg_ff[g][`UPC_CFG_RSTSEL_LSB+1:`UPC_CFG_RSTSEL_LSB]),
				.prgFunc(cfg_ff[g][`UPC_CFG_PRG_LSB+1:`UPC_CFG_PRG_LSB]),
				.filtSel(cfg_ff[g][`UPC_CFG_FILT_LSB+3:`UPC_CFG_FILT_LSB]),
				.logReset(logRst_ff[g]),
				.clearNow(clearNow_ff[g]),
				.count_ff(count[g])
			);
		end
	endgenerate

	// Logical reset: chosen slot value greater than zero, registered once
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			logRst_ff <= 4'h0;
		end else begin
			for (kLr = 0; kLr < 4; kLr = kLr + 1)
				logRst_ff[kLr] <= $signed(logChanVal[cfg_ff[kLr][`UPC_CFG_LOGSEL_LSB+1:
					`UPC_CFG_LOGSEL_LSB]*32 +: 32]) > 0;
		end
	end

	// Limit flags from signed compares; registered so outputs come from flops
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			below_low_flag_ff <= 4'h0;
			above_high_flag_ff <= 4'h0;
		end else begin
			for (kFl = 0; kFl < 4; kFl = kFl + 1) begin
				below_low_flag_ff[kFl] <= $signed(count[kFl]) < $signed(loLim_ff[kFl]);
				above_high_flag_ff[kFl] <= $signed(count[kFl]) > $signed(hiLim_ff[kFl]);
			end
		end
	end

	// Rising edges of the flags are the interrupt events
	always @* begin
		for (kFr = 0; kFr < 4; kFr = kFr + 1) begin
			flagRise[2*kFr] = ($signed(count[kFr]) < $signed(loLim_ff[kFr])) &
				~below_low_flag_ff[kFr];
			flagRise[2*kFr+1] = ($signed(count[kFr]) > $signed(hiLim_ff[kFr])) &
				~above_high_flag_ff[kFr];
		end
	end

	// Write address decode
	assign doWrite = awHave_ff & wHave_ff & ~s_axi_bvalid;
	always @* begin
		wOff = awAddr_ff - `UPC_OFS_CH_BASE;
		wCh = wOff[6:5];
		wSub = wOff[4:2];
		wOk = (awAddr_ff == `UPC_OFS_IRQ_STAT) || (awAddr_ff == `UPC_OFS_IRQ_MASK) ||
			((awAddr_ff >= `UPC_OFS_CH_BASE) && (awAddr_ff[1:0] == 2'h0) &&
			(wOff[7] == 1'b0) && (wSub <= `UPC_SUB_HILIM)); // Nothing past channel four
	end

	// Byte-lane merge over the addressed register's old value
	always @* begin
		if (awAddr_ff == `UPC_OFS_IRQ_MASK)
			merged = {24'h0, irqMask_ff};
		else if (wSub == `UPC_SUB_LOLIM)
			merged = loLim_ff[wCh];
		else if (wSub == `UPC_SUB_HILIM)
			merged = hiLim_ff[wCh];
		else
			merged = cfg_ff[wCh];
		for (kMg = 0; kMg < 4; kMg = kMg + 1)
			if (wStrb_ff[kMg])
				merged[8*kMg +: 8] = wData_ff[8*kMg +: 8];
	end

	// Write channel: take address and data in either order, answer after both
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			awHave_ff <= 1'b0;
			wHave_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h0;
			wStrb_ff <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= OKAY;
			irqMask_ff <= 8'h00;
			irqStat_ff <= 8'h00;
			clearNow_ff <= 4'h0;
			for (k = 0; k < 4; k = k + 1) begin
				cfg_ff[k] <= `UPC_CFG_RST;
				loLim_ff[k] <= `UPC_LOLIM_RST;
				hiLim_ff[k] <= `UPC_HILIM_RST;
			end
		end else begin
			clearNow_ff <= 4'h0;
			// No new address or data is taken while a response still waits
			s_axi_awready <= ~awHave_ff & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
			s_axi_wready <= ~wHave_ff & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// Events set status; set wins over a same-cycle write-one clear
			irqStat_ff <= irqStat_ff | flagRise;
			if (doWrite) begin
				awHave_ff <= 1'b0;
				wHave_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wOk ? OKAY : SLVERR;
				if (awAddr_ff == `UPC_OFS_IRQ_STAT) begin
					irqStat_ff <= (irqStat_ff & ~(wStrb_ff[0] ? wData_ff[7:0] : 8'h00))
						| flagRise;
				end else if (awAddr_ff == `UPC_OFS_IRQ_MASK) begin
					irqMask_ff <= merged[7:0];
				end else if (wOk) begin
					case (wSub)
						`UPC_SUB_CFG: begin
							// Clear-now bit is a command, not stored
							cfg_ff[wCh] <= merged & ~(32'h1 << `UPC_CFG_CLEARNOW_BIT);
							clearNow_ff[wCh] <= wStrb_ff[3] &
								wData_ff[`UPC_CFG_CLEARNOW_BIT];
						end
						`UPC_SUB_LOLIM: begin
							loLim_ff[wCh] <= merged;
						end
						`UPC_SUB_HILIM: begin
							hiLim_ff[wCh] <= merged;
						end
						default: begin
							clearNow_ff <= 4'h0;
						end
					endcase
				end
			end
		end
	end

	// Interrupt level from unmasked status
	always @(posedge ref_clk or posedge reset) begin
		if (reset)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irqStat_ff & irqMask_ff);
	end

	// Read decode
	always @* begin
		rOff = s_axi_araddr - `UPC_OFS_CH_BASE;
		rCh = rOff[6:5];
		rSub = rOff[4:2];
		rdVal = 32'h0;
		rdOk = 1'b1;
		if (s_axi_araddr == `UPC_OFS_IRQ_STAT) begin
			rdVal = {24'h0, irqStat_ff};
		end else if (s_axi_araddr == `UPC_OFS_IRQ_MASK) begin
			rdVal = {24'h0, irqMask_ff};
		end else if (s_axi_araddr >= `UPC_OFS_CH_BASE && s_axi_araddr[1:0] == 2'h0 &&
			rOff[7] == 1'b0) begin
			case (rSub)
				`UPC_SUB_CFG: rdVal = cfg_ff[rCh];
				`UPC_SUB_LOLIM: rdVal = loLim_ff[rCh];
				`UPC_SUB_HILIM: rdVal = hiLim_ff[rCh];
				`UPC_SUB_COUNT: rdVal = count[rCh];
				`UPC_SUB_FLAGS: rdVal = {30'h0, above_high_flag_ff[rCh], below_low_flag_ff[rCh]};
				default: rdOk = 1'b0;
			endcase
		end else begin
			rdOk = 1'b0;
		end
	end

	// Read channel: one request at a time, data one cycle after acceptance
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdVal;
				s_axi_rresp <= rdOk ? OKAY : SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // upc_top

/* File: testbench/upc_asserts.sv */
// Checker for the pulse counter top: bus handshake and answer timing.
// Bound to upc_top after the module; sees only its ports.
`timescale 1ns/1ps
module upc_asserts (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Bus handshakes
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	// Interrupt and flags
	input wire irq_ff,
	input wire [3:0] above_high_flag_ff
);
	// One domain, so one clock and one disable
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Readies are single-cycle pulses
	AST_AWPULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held");
	AST_ARPULSE: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready held");
	// Read data one cycle after the address is taken
	AST_RLAT: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("rvalid late");
	// Response two cycles after the later address or data handshake
	AST_BLAT: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready || s_axi_wready, 2))
		else $error("bvalid without handshake");
	// Answers stand until taken
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	// No new write taken while a response waits
	AST_NOREQ: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	// Only OKAY or SLVERR, and refused reads return zero
	AST_BRESP: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
		else $error("bad bresp");
	AST_RZERO: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |->
		s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("bad refused read");
	// Main scenarios reached
	COV_WR: cover property (s_axi_bvalid && s_axi_bready);
	COV_RD: cover property (s_axi_rvalid && s_axi_rready);
	COV_IRQ: cover property ($rose(irq_ff));
	COV_HI: cover property ($rose(above_high_flag_ff[0]));
endmodule // upc_asserts
bind upc_top upc_asserts CHK (.*);

/* File: testbench/upc_field_src.sv */
// Field pulse sources for the four counter channels.
// Assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/1ps
module upc_field_src (
	// Clock
	input wire ref_clk,
	// Field pins
	output reg [3:0] cntA,
	output reg [3:0] cntB,
	output reg [3:0] prgIn,
	output reg [3:0] rstIn
);
	// Contacts open at start
	initial begin
		cntA <= 4'h0;
		cntB <= 4'h0;
		prgIn <= 4'h0;
		rstIn <= 4'h0;
	end
	// Hold a level ten cycles: syncing and edge logic must settle first
	task lvl(input int p, input int c, input bit v);
		case (p)
			0: cntA[c] <= v;
			1: cntB[c] <= v;
			2: prgIn[c] <= v;
			default: rstIn[c] <= v;
		endcase
		repeat (10) @(posedge ref_clk);
	endtask
	// Whole pulses, one rising edge each
	task pulse(input int p, input int c, input int k);
		repeat (k) begin
			lvl(p, c, 1'b1);
			lvl(p, c, 1'b0);
		end
	endtask
endmodule // upc_field_src

/* File: testbench/test_universal_pulse_counter.sv */
// Bench for the pulse counter: bus master tasks and counting sequences.
// Assumes the field source model and the bound checker beside it.
`timescale 1ns/1ps
module test_universal_pulse_counter;
	// Clock, reset, bus master and logical values
	reg ref_clk = 1'b0;
	reg reset = 1'b1;
	reg [7:0] s_axi_awaddr = 8'h00;
	reg [7:0] s_axi_araddr = 8'h00;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	// Answers are always accepted at once
	reg s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	reg [127:0] logChanVal = 128'h0;
	wire [3:0] cntA, cntB, prgIn, rstIn, below_low_flag_ff, above_high_flag_ff;
	wire [31:0] s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire irq_ff, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int error_cnt = 0;
	int checked = 0;
	always #25 ref_clk = ~ref_clk;
	upc_top DUT (.*);
	upc_field_src SRC (.*);
	// Compare and count
	task chk(input [31:0] seen, input [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task report_and_stop;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// One clock of a bounded wait
	task step(inout int n);
		@(posedge ref_clk);
		n++;
		if (n > 60) begin
			error_cnt++;
			report_and_stop;
		end
	endtask
	// Write: both channels offered, each released when taken
	task wr(input [7:0] a, input [31:0] d, input [1:0] er = 2'h0);
		int n;
		bit aw, w;
		n = 0;
		aw = 0;
		w = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w)) begin
			step(n);
			if (s_axi_awready === 1'b1) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) step(n);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	// Read and compare data and response
	task rd(input [7:0] a, input [31:0] exp, input [1:0] er = 2'h0);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do step(n); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do step(n); while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rdata, exp);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		// Reset values, unmapped and read-only places; nothing past channel four
		wr(8'ha0, 32'h3, 2'h2);
		rd(8'h20, 32'h0);
		rd(8'h28, 32'hffffffff);
		rd(8'h08, 32'h0, 2'h2);
		rd(8'ha0, 32'h0, 2'h2);
		wr(8'h2c, 32'h5, 2'h2);
		// Channel zero limits two to four, stale events cleared
		wr(8'h24, 32'h2);
		wr(8'h28, 32'h4);
		wr(8'h00, 32'hff);
		rd(8'h00, 32'h0);
		chk({31'h0, below_low_flag_ff[0]}, 32'h1);
		SRC.pulse(0, 0, 3);
		SRC.pulse(1, 0, 2);
		rd(8'h2c, 32'h5);
		chk({28'h0, below_low_flag_ff}, 32'h0);
		chk({28'h0, above_high_flag_ff}, 32'hf);
		rd(8'h00, 32'h2);
		// Interrupt masked, unmasked, cleared
		chk({31'h0, irq_ff}, 32'h0);
		wr(8'h04, 32'h2);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq_ff}, 32'h1);
		wr(8'h00, 32'h2);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq_ff}, 32'h0);
		// Inhibit holds; a disabled programming input is ignored
		wr(8'h20, 32'h20);
		SRC.lvl(2, 0, 1);
		SRC.pulse(0, 0, 1);
		rd(8'h2c, 32'h5);
		wr(8'h20, 32'h0);
		SRC.pulse(0, 0, 1);
		rd(8'h2c, 32'h6);
		SRC.lvl(2, 0, 0);
		// Manual clear, command bit reads back zero
		wr(8'h20, 32'h80000000);
		rd(8'h20, 32'h0);
		rd(8'h2c, 32'h0);
		// Reset selections: input, none, logical, both
		wr(8'h20, 32'h8);
		SRC.lvl(3, 0, 1);
		SRC.pulse(0, 0, 1);
		rd(8'h2c, 32'h0);
		wr(8'h20, 32'h0);
		SRC.pulse(0, 0, 1);
		rd(8'h2c, 32'h1);
		SRC.lvl(3, 0, 0);
		wr(8'h20, 32'h1004);
		logChanVal[63:32] <= 32'hffffffff;
		SRC.pulse(0, 0, 1);
		rd(8'h2c, 32'h2);
		logChanVal[63:32] <= 32'h1;
		repeat (4) @(posedge ref_clk);
		rd(8'h2c, 32'h0);
		logChanVal[63:32] <= 32'h0;
		wr(8'h20, 32'h100c);
		SRC.pulse(0, 0, 1);
		rd(8'h2c, 32'h1);
		SRC.lvl(3, 0, 1);
		rd(8'h2c, 32'h0);
		SRC.lvl(3, 0, 0);
		// Subtractive, then swapped by the programming input
		wr(8'h40, 32'h1);
		SRC.pulse(0, 1, 3);
		SRC.pulse(1, 1, 1);
		rd(8'h4c, 32'h2);
		wr(8'h40, 32'h11);
		SRC.lvl(2, 1, 1);
		SRC.pulse(0, 1, 1);
		rd(8'h4c, 32'h1);
		SRC.lvl(2, 1, 0);
		// Top filter setting drops a ten-cycle pulse as a bounce
		wr(8'h40, 32'h900);
		SRC.pulse(0, 1, 1);
		rd(8'h4c, 32'h1);
		// Single quadrature; edges of the second input not counted
		wr(8'h60, 32'h2);
		SRC.lvl(1, 2, 1);
		SRC.pulse(0, 2, 2);
		SRC.lvl(1, 2, 0);
		SRC.pulse(0, 2, 1);
		rd(8'h6c, 32'h1);
		wr(8'h60, 32'h12);
		SRC.lvl(2, 2, 1);
		SRC.pulse(0, 2, 1);
		rd(8'h6c, 32'h2);
		// Four-times quadrature: down, up, up
		wr(8'h80, 32'h3);
		SRC.lvl(0, 3, 1);
		SRC.lvl(1, 3, 1);
		SRC.lvl(0, 3, 0);
		SRC.lvl(0, 3, 1);
		rd(8'h8c, 32'h1);
		wr(8'h80, 32'h13);
		SRC.lvl(2, 3, 1);
		SRC.lvl(1, 3, 0);
		SRC.lvl(1, 3, 1);
		rd(8'h8c, 32'h0);
		report_and_stop;
	end
endmodule // test_universal_pulse_counter
